// file: verilog/wiper_pkg.sv
package wiper_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_MS = 1;
   // cycles per millisecond tick
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int DEBOUNCE_MS = 15;
   localparam int SLOW_STEP_MS = 250;
   localparam int FAST_STEP_MS = 50;
   localparam int SLOW_SPAN_MS = 1000;
   localparam int IDLE_SAVE_MS = 2000;
   localparam int SHUTDOWN_MS = 2000;
   localparam int NV_WRITE_MS = 10;

   // ---------------------------------------------------------------
   // widths and reset values
   // ---------------------------------------------------------------
   localparam int POS_W = 5;
   localparam int TAPS = 32;
   localparam int MS_W = 12;
   localparam logic [4:0] POS_MIN = 5'h00;
   localparam logic [4:0] POS_MAX = 5'h1F;
   localparam logic [4:0] POS_RESET = 5'h00;

   // debounced view of the three pins, 1 means held low
   typedef struct packed {
      logic up;
      logic down;
      logic store;
   } pins_t;

   // non-volatile store request and its write data
   typedef struct packed {
      logic writeReq;
      logic [4:0] data;
   } nvm_t;

endpackage

// file: verilog/pin_debounce.sv
`timescale 1ns/100ps
module pin_debounce
   #(parameter int MS_W = 12,
     parameter int HOLD_MS = 15)
   (input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic pinN,
    output logic held,
    output logic rise);

   // ---------------------------------------------------------------
   // two-stage synchroniser, then a millisecond-based filter
   // ---------------------------------------------------------------
   logic sync1Reg;
   logic sync2Reg;
   logic [MS_W-1:0] cntReg;
   logic heldReg;
   logic prevReg;
   wire lowNow = ~sync2Reg;
   wire lowLong = (cntReg >= MS_W'(HOLD_MS));

   // pin idles high through pull-up, so reset to high
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sync1Reg <= 1'b1;
         sync2Reg <= 1'b1;
      end
      else
      begin
         sync1Reg <= pinN;
         sync2Reg <= sync1Reg;
      end
   end

   // short lows reset the count and never set held
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cntReg <= '0;
         heldReg <= 1'b0;
         prevReg <= 1'b0;
      end
      else
      begin
         prevReg <= heldReg;
         if (!lowNow)
         begin
            cntReg <= '0;
            heldReg <= 1'b0;
         end
         else if (tick && !lowLong)
            cntReg <= cntReg + MS_W'(1);
         else if (lowLong)
            heldReg <= 1'b1;
      end
   end

   assign held = heldReg;
   assign rise = prevReg & ~heldReg; // valid release
endmodule

// file: verilog/push_button_wiper_control.sv
`timescale 1ns/100ps
module push_button_wiper_control
   #(parameter int TICK_CYCLES = wiper_pkg::TICK_CYCLES,
     parameter int NV_WRITE_MS = wiper_pkg::NV_WRITE_MS)
   (input wire logic clk,
    input wire logic rst,
    input wire logic stepUpButtonN,
    input wire logic stepDownButtonN,
    input wire logic storeEnablePinN,
    input wire logic [wiper_pkg::POS_W-1:0] recallData,
    output logic [wiper_pkg::TAPS-1:0] tapSelect,
    output logic highTerminalOn,
    output logic nvmWrite,
    output logic [wiper_pkg::POS_W-1:0] nvmData,
    output logic [wiper_pkg::POS_W-1:0] wiperPos);
   import wiper_pkg::*;

   // ---------------------------------------------------------------
   // millisecond tick
   // ---------------------------------------------------------------
   logic [15:0] divReg;
   logic tickReg;
   wire divEnd = (divReg == 16'(TICK_CYCLES - 1));

   // one shared tick keeps every interval on the same base
   // free-running divider: its phase against a press costs up to one ms
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         divReg <= '0;
         tickReg <= 1'b0;
      end
      else
      begin
         divReg <= divEnd ? 16'h0000 : divReg + 16'h0001;
         tickReg <= divEnd;
      end
   end

   // ---------------------------------------------------------------
   // debounced pins
   // ---------------------------------------------------------------
   pins_t held;
   pins_t rise;

   pin_debounce #(.MS_W(MS_W), .HOLD_MS(DEBOUNCE_MS)) upDb
      (.clk(clk), .rst(rst), .tick(tickReg), .pinN(stepUpButtonN),
       .held(held.up), .rise(rise.up));
   pin_debounce #(.MS_W(MS_W), .HOLD_MS(DEBOUNCE_MS)) downDb
      (.clk(clk), .rst(rst), .tick(tickReg), .pinN(stepDownButtonN),
       .held(held.down), .rise(rise.down));
   pin_debounce #(.MS_W(MS_W), .HOLD_MS(DEBOUNCE_MS)) storeDb
      (.clk(clk), .rst(rst), .tick(tickReg), .pinN(storeEnablePinN),
       .held(held.store), .rise(rise.store));

   // raw store level for power-up sampling, two flops deep
   logic stSync1Reg;
   logic stSync2Reg;
   // no reset here: it must follow the pin while reset is still held,
   // otherwise the strap would read as high at the first edge after
   always_ff @(posedge clk)
   begin
      stSync1Reg <= storeEnablePinN;
      stSync2Reg <= stSync1Reg;
   end

   // ---------------------------------------------------------------
   // control state machine
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_BOOT, ST_IDLE, ST_STEP, ST_BLOCK, ST_DUAL, ST_SHUT, ST_WRITE
   } state_t;

   state_t stateReg;
   state_t stateNext;
   logic [4:0] posReg;
   logic [4:0] posNext;
   logic [4:0] savedReg;
   logic [4:0] savedNext;
   logic autoSaveReg;
   logic autoSaveNext;
   logic [MS_W-1:0] holdMsReg;
   logic [MS_W-1:0] holdMsNext;
   logic [MS_W-1:0] stepMsReg;
   logic [MS_W-1:0] stepMsNext;
   logic [MS_W-1:0] idleMsReg;
   logic [MS_W-1:0] idleMsNext;
   logic dirtyReg;
   logic dirtyNext;
   logic writeNext;
   logic hiOnReg;
   logic hiOnNext;
   // set once the store pin is seen high inside shutdown
   logic storeFreeReg;
   logic storeFreeNext;

   // decoded conditions
   wire anyBtn = held.up | held.down;
   wire bothBtn = held.up & held.down;
   wire upOnly = held.up & ~held.down;
   wire atMax = (posReg == POS_MAX);
   wire atMin = (posReg == POS_MIN);
   // hold time stops counting at the slow span, so fast scan sticks
   wire inFast = (holdMsReg >= MS_W'(SLOW_SPAN_MS));
   wire [MS_W-1:0] stepGap = inFast ? MS_W'(FAST_STEP_MS)
                                    : MS_W'(SLOW_STEP_MS);
   wire stepDue = tickReg && (stepMsReg + MS_W'(1) >= stepGap);
   // manual mode with store pin low locks the buttons
   wire manualLock = ~autoSaveReg & held.store;

   // saturating one-tap move
   function automatic logic [4:0] stepPos(input logic [4:0] p,
                                          input logic up);
      if (up)
         stepPos = (p == POS_MAX) ? p : p + 5'h01;
      else
         stepPos = (p == POS_MIN) ? p : p - 5'h01;
   endfunction

   // next-state logic
   always_comb
   begin
      stateNext = stateReg;
      posNext = posReg;
      savedNext = savedReg;
      autoSaveNext = autoSaveReg;
      holdMsNext = holdMsReg;
      stepMsNext = stepMsReg;
      idleMsNext = idleMsReg;
      dirtyNext = dirtyReg;
      writeNext = 1'b0;
      hiOnNext = hiOnReg;
      storeFreeNext = storeFreeReg;
      unique case (stateReg)
         ST_BOOT:
         begin
            // two flops settled while reset was held; take strap and recall
            autoSaveNext = ~stSync2Reg;
            posNext = recallData;
            stateNext = ST_IDLE;
         end
         ST_IDLE:
         begin
            holdMsNext = '0;
            stepMsNext = '0;
            if (tickReg && idleMsReg != MS_W'(IDLE_SAVE_MS))
               idleMsNext = idleMsReg + MS_W'(1);
            if (manualLock)
               stateNext = ST_BLOCK;
            else if (bothBtn)
            begin
               // both arrived within the same millisecond tick
               stateNext = ST_DUAL;
               idleMsNext = '0;
            end
            else if (anyBtn)
            begin
               posNext = stepPos(posReg, upOnly);
               dirtyNext = dirtyReg | (upOnly ? ~atMax : ~atMin);
               idleMsNext = '0;
               stateNext = ST_STEP;
            end
            else if (~autoSaveReg && rise.store)
            begin
               writeNext = 1'b1;
               stateNext = ST_WRITE;
            end
            else if (autoSaveReg && dirtyReg &&
                     idleMsReg == MS_W'(IDLE_SAVE_MS))
            begin
               writeNext = 1'b1;
               dirtyNext = 1'b0;
               stateNext = ST_WRITE;
            end
         end
         ST_STEP:
         begin
            idleMsNext = '0;
            if (!anyBtn)
               stateNext = ST_IDLE;
            else if (bothBtn)
               stateNext = ST_BLOCK;
            else if (tickReg)
            begin
               if (!inFast)
                  holdMsNext = holdMsReg + MS_W'(1);
               if (stepDue)
               begin
                  // spacing: slow then fast
                  stepMsNext = '0;
                  posNext = stepPos(posReg, upOnly);
                  dirtyNext = dirtyReg | (upOnly ? ~atMax : ~atMin);
               end
               else
                  stepMsNext = stepMsReg + MS_W'(1);
            end
         end
         ST_BLOCK:
         begin
            idleMsNext = '0;
            // a leftover step count would stretch the next write timer
            stepMsNext = '0;
            // wait for every button and the lock to clear; a manual store press
            // still held in ST_IDLE passes through here, so its release acts here
            if (!anyBtn && !manualLock && !autoSaveReg && rise.store)
            begin
               writeNext = 1'b1;
               stateNext = ST_WRITE;
            end
            else if (!anyBtn && !manualLock)
               stateNext = ST_IDLE;
         end
         ST_DUAL:
         begin
            if (!bothBtn)
               stateNext = anyBtn ? ST_BLOCK : ST_IDLE;
            else if (tickReg)
            begin
               holdMsNext = holdMsReg + MS_W'(1);
               if (holdMsReg + MS_W'(1) >= MS_W'(SHUTDOWN_MS))
               begin
                  savedNext = posReg;
                  posNext = POS_MIN;
                  hiOnNext = 1'b0;
                  storeFreeNext = 1'b0; // store pin must rearm
                  stateNext = ST_SHUT;
               end
            end
         end
         ST_SHUT:
         begin
            // a button press leaves only after the entry buttons were let go; a store pin
            // strapped low must go high once here before its low counts
            if (!held.store)
               storeFreeNext = 1'b1;
            if ((held.store && storeFreeReg) ||
                (anyBtn && holdMsReg == '0))
            begin
               posNext = savedReg;
               hiOnNext = 1'b1;
               stateNext = ST_BLOCK;
            end
            else if (!anyBtn)
               holdMsNext = '0;
         end
         ST_WRITE:
         begin
            // all pins ignored until the write time is spent
            if (tickReg)
               stepMsNext = stepMsReg + MS_W'(1);
            if (stepMsReg == MS_W'(NV_WRITE_MS))
            begin
               stepMsNext = '0;
               idleMsNext = '0;
               stateNext = ST_BLOCK;
            end
         end
      endcase
   end

   // state and datapath registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stateReg <= ST_BOOT;
         posReg <= POS_RESET;
         savedReg <= POS_RESET;
         autoSaveReg <= 1'b0;
         holdMsReg <= '0;
         stepMsReg <= '0;
         idleMsReg <= '0;
         dirtyReg <= 1'b0;
         hiOnReg <= 1'b1;
         storeFreeReg <= 1'b0;
      end
      else
      begin
         stateReg <= stateNext;
         posReg <= posNext;
         savedReg <= savedNext;
         autoSaveReg <= autoSaveNext;
         holdMsReg <= holdMsNext;
         stepMsReg <= stepMsNext;
         idleMsReg <= idleMsNext;
         dirtyReg <= dirtyNext;
         hiOnReg <= hiOnNext;
         storeFreeReg <= storeFreeNext;
      end
   end

   // ---------------------------------------------------------------
   // outputs, all registered
   // ---------------------------------------------------------------
   // the tap follows posNext so tapSelect and wiperPos move together
   logic [TAPS-1:0] tapReg;
   nvm_t nvmReg;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tapReg <= '0;
         nvmReg <= '0;
      end
      else
      begin
         // one-hot, exactly one switch on
         tapReg <= TAPS'(1) << posNext;
         // data is captured with the strobe and stands until the next
         nvmReg.writeReq <= writeNext;
         nvmReg.data <= writeNext ? posReg : nvmReg.data;
      end
   end

   assign tapSelect = tapReg;
   assign highTerminalOn = hiOnReg;
   assign nvmWrite = nvmReg.writeReq;
   assign nvmData = nvmReg.data;
   assign wiperPos = posReg;
endmodule

// file: verif/wiper_props.sv
`timescale 1ns/100ps
module wiper_props
   import wiper_pkg::*;
   #(parameter int TICK_CYCLES = 20)
   (input wire logic clk,
    input wire logic rst,
    input wire logic stepUpButtonN,
    input wire logic stepDownButtonN,
    input wire logic storeEnablePinN,
    input wire logic [POS_W-1:0] recallData,
    input wire logic [TAPS-1:0] tapSelect,
    input wire logic highTerminalOn,
    input wire logic nvmWrite,
    input wire logic [POS_W-1:0] nvmData,
    input wire logic [POS_W-1:0] wiperPos);
   // ----
   // helpers
   // ----
   // one tick of slack: the debounce may start mid-tick
   localparam int DB_MIN = 14 * TICK_CYCLES;
   logic [15:0] gap_reg;
   logic [1:0] run_reg;
   logic [4:0] prePos_reg;
   logic settled;
   assign settled = run_reg[1];
   // gap counter saturates so a long idle spell cannot wrap
   always_ff @(posedge clk)
   begin
      run_reg <= rst ? 2'h0 : {run_reg[0], 1'b1};
      gap_reg <= (rst || $changed(wiperPos)) ? 16'h0000 :
                 gap_reg + {15'h0000, gap_reg != 16'hFFFF};
      if (highTerminalOn)
         prePos_reg <= wiperPos;
   end
   // ----
   // properties
   // ----
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_quiet;
      $stable(wiperPos)[*8];
   endsequence
   sequence s_parked;
      wiperPos == POS_MIN && tapSelect == 32'h0000_0001;
   endsequence
   a_recall_load: assert property ($fell(rst) |=> wiperPos == recallData)
      else $error("wiper not loaded from recall");
   a_tap_onehot: assert property (settled |->
      tapSelect == (32'h0000_0001 << wiperPos))
      else $error("tap select not one-hot on wiper");
   a_step_unit: assert property (settled && $changed(wiperPos) &&
      highTerminalOn && $past(highTerminalOn) |->
      wiperPos == $past(wiperPos) + 5'h01 ||
      wiperPos == $past(wiperPos) - 5'h01)
      else $error("wiper moved by more than one tap");
   a_no_wrap: assert property (settled && highTerminalOn &&
      $past(highTerminalOn) |->
      !($past(wiperPos) == POS_MAX && wiperPos == POS_MIN) &&
      !($past(wiperPos) == POS_MIN && wiperPos == POS_MAX))
      else $error("wiper wrapped around");
   a_step_gap: assert property (settled && $changed(wiperPos) &&
      highTerminalOn && $past(highTerminalOn) |-> gap_reg >= DB_MIN)
      else $error("steps closer than debounce");
   a_write_pulse: assert property (nvmWrite |=> !nvmWrite)
      else $error("write strobe longer than one cycle");
   a_write_data: assert property (nvmWrite |-> nvmData == wiperPos)
      else $error("write data differs from wiper");
   a_write_quiet: assert property (nvmWrite |=> s_quiet)
      else $error("wiper moved during write");
   a_park_hold: assert property (!highTerminalOn |-> s_parked)
      else $error("shutdown wiper not at low end");
   a_park_cause: assert property ($fell(highTerminalOn) |->
      $past(stepUpButtonN, 8) == 1'b0 && $past(stepDownButtonN, 8) == 1'b0)
      else $error("shutdown without both buttons");
   a_restore_pos: assert property (settled && $rose(highTerminalOn) |->
      wiperPos == prePos_reg)
      else $error("shutdown exit lost position");
endmodule

// file: verif/button_model.sv
`timescale 1ns/100ps
module button_model
   (input wire logic pressUp,
    input wire logic pressDown,
    input wire logic pressStore,
    output logic stepUpButtonN,
    output logic stepDownButtonN,
    output logic storeEnablePinN);
   // ----
   // switches to ground
   // ----
   // an open switch leaves each pin on its pull-up, so idle reads high
   assign stepUpButtonN = !pressUp;
   assign stepDownButtonN = !pressDown;
   assign storeEnablePinN = !pressStore;
endmodule

// file: verif/test_push_button_wiper_control.sv
`timescale 1ns/100ps
module test_push_button_wiper_control;
   import wiper_pkg::*;
   // ----
   // set-up
   // ----
   // short tick keeps the two-second waits cheap
   localparam int TC = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic pressUp = 1'b0;
   logic pressDown = 1'b0;
   logic pressStore = 1'b0;
   logic upN, downN, storeN, highTerminalOn, nvmWrite;
   logic [4:0] recallData = 5'h00;
   logic [4:0] nvmData, wiperPos;
   logic [31:0] tapSelect;
   int failures = 0;
   int check_count = 0;
   int cycles = 0;
   int n;
   always #25 clk = ~clk;
   button_model i_btn (.pressUp(pressUp), .pressDown(pressDown),
      .pressStore(pressStore), .stepUpButtonN(upN),
      .stepDownButtonN(downN), .storeEnablePinN(storeN));
   push_button_wiper_control #(.TICK_CYCLES(TC), .NV_WRITE_MS(10)) i_dut
      (.clk(clk), .rst(rst), .stepUpButtonN(upN), .stepDownButtonN(downN),
       .storeEnablePinN(storeN), .recallData(recallData),
       .tapSelect(tapSelect), .highTerminalOn(highTerminalOn),
       .nvmWrite(nvmWrite), .nvmData(nvmData), .wiperPos(wiperPos));
   // ----
   // helpers
   // ----
   task automatic fail(input string msg);
      failures++;
      $display("unexpected at %0t: %s", $time, msg);
   endtask
   task automatic chk_pos(input logic [4:0] got, input logic [4:0] exp);
      check_count++;
      if (got !== exp) fail("wiper position");
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) fail("flag value");
   endtask
   task automatic chk_range(input int got, input int lo, input int hi);
      check_count++;
      if (got < lo * TC || got > hi * TC) fail("step spacing");
   endtask
   task automatic ms(input int m);
      repeat (m * TC) @(posedge clk);
      #1;
   endtask
   // cycles until the wiper moves, bounded at half a second
   task automatic wait_step(output int c);
      logic [4:0] p;
      p = wiperPos;
      c = 0;
      while (wiperPos === p && c < 500 * TC)
      begin
         @(posedge clk);
         #1;
         c++;
      end
   endtask
   task automatic wait_write(input int lim, output int c);
      c = 0;
      while (nvmWrite !== 1'b1 && c < lim)
      begin
         @(posedge clk);
         #1;
         c++;
      end
   endtask
   task automatic do_reset(input logic storeLow, input logic [4:0] recall);
      rst = 1'b1;
      pressStore = storeLow;
      recallData = recall;
      repeat (16) @(posedge clk);
      #1;
      rst = 1'b0;
      ms(1);
      chk_pos(wiperPos, recall);
      chk_bit(tapSelect === (32'h0000_0001 << recall), 1'b1);
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_press;
      pressUp = 1'b1;
      ms(10);
      pressUp = 1'b0;
      ms(30);
      chk_pos(wiperPos, 5'h0A);
      pressUp = 1'b1;
      ms(100);
      pressUp = 1'b0;
      ms(30);
      chk_pos(wiperPos, 5'h0B);
      pressDown = 1'b1;
      ms(100);
      pressDown = 1'b0;
      ms(30);
      chk_pos(wiperPos, 5'h0A);
   endtask
   task automatic t_scan;
      pressUp = 1'b1;
      wait_step(n);
      wait_step(n);
      chk_range(n, 100, 390);
      ms(1100);
      wait_step(n);
      wait_step(n);
      chk_range(n, 25, 78);
      for (int k = 0; k < 40 && wiperPos !== POS_MAX; k++) wait_step(n);
      ms(200);
      chk_pos(wiperPos, POS_MAX);
      pressUp = 1'b0;
      ms(100);
      chk_pos(wiperPos, POS_MAX);
      wait_write(2200 * TC, n);
      chk_bit(n >= 1500 * TC && n < 2200 * TC, 1'b1);
      chk_pos(nvmData, POS_MAX);
   endtask
   task automatic t_manual;
      pressUp = 1'b1;
      ms(100);
      pressUp = 1'b0;
      wait_write(2200 * TC, n);
      chk_bit(n < 2200 * TC, 1'b0);
      pressStore = 1'b1;
      ms(30);
      pressStore = 1'b0;
      wait_write(40 * TC, n);
      chk_bit(n < 40 * TC, 1'b1);
      chk_pos(nvmData, 5'h04);
      ms(30);
      pressStore = 1'b1;
      ms(30);
      pressUp = 1'b1;
      ms(100);
      pressUp = 1'b0;
      ms(30);
      chk_pos(wiperPos, 5'h04);
      pressStore = 1'b0;
      ms(60);
   endtask
   // second button joins late: no shutdown, no repeats
   task automatic t_block;
      pressDown = 1'b1;
      ms(100);
      pressUp = 1'b1;
      ms(2100);
      chk_bit(highTerminalOn, 1'b1);
      chk_pos(wiperPos, 5'h03);
      pressUp = 1'b0;
      pressDown = 1'b0;
      ms(30);
      chk_pos(wiperPos, 5'h03);
   endtask
   task automatic t_shutdown;
      pressUp = 1'b1;
      pressDown = 1'b1;
      ms(2100);
      chk_bit(highTerminalOn, 1'b0);
      chk_pos(wiperPos, POS_MIN);
      pressUp = 1'b0;
      pressDown = 1'b0;
      ms(50);
      chk_bit(highTerminalOn, 1'b0);
      pressStore = 1'b1;
      ms(30);
      chk_bit(highTerminalOn, 1'b1);
      chk_pos(wiperPos, 5'h03);
      pressStore = 1'b0;
      ms(30);
   endtask
   // ----
   // run control
   // ----
   task automatic report_and_stop;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // the full run needs about 45000 cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 90000)
      begin
         fail("run timed out");
         report_and_stop;
      end
   end
   initial
   begin
      do_reset(1'b1, 5'h0A);
      t_press;
      t_scan;
      do_reset(1'b0, 5'h03);
      t_manual;
      t_block;
      t_shutdown;
      report_and_stop;
   end
endmodule
bind push_button_wiper_control wiper_props #(.TICK_CYCLES(TICK_CYCLES))
   i_props (.clk(clk), .rst(rst), .stepUpButtonN(stepUpButtonN),
   .stepDownButtonN(stepDownButtonN), .storeEnablePinN(storeEnablePinN),
   .recallData(recallData), .tapSelect(tapSelect),
   .highTerminalOn(highTerminalOn), .nvmWrite(nvmWrite),
   .nvmData(nvmData), .wiperPos(wiperPos));
